// ===== verilog/sbir_pkg.sv
package sbir_pkg;

	// Register bus widths
	localparam int unsigned SBIR_ADDR_W = 8;
	localparam int unsigned SBIR_DATA_W = 8;

	// Register offsets
	localparam logic [7:0] SBIR_ADDR_MODE_STRAP = 8'h13;
	localparam logic [7:0] SBIR_ADDR_SELF_TEST = 8'h14;
	localparam logic [7:0] SBIR_ADDR_LEVEL_SEL = 8'h15;
	localparam logic [7:0] SBIR_ADDR_WATCHDOG = 8'h16;
	localparam logic [7:0] SBIR_ADDR_PASSTHRU = 8'h17;
	localparam logic [7:0] SBIR_ADDR_SCL_HIGH = 8'h18;

	// Reset values
	localparam logic [7:0] SBIR_RST_MODE_STRAP = 8'h88;
	localparam logic [7:0] SBIR_RST_SELF_TEST = 8'h00;
	localparam logic [7:0] SBIR_RST_LEVEL_SEL = 8'h01;
	localparam logic [7:0] SBIR_RST_WATCHDOG = 8'hFE;
	localparam logic [7:0] SBIR_RST_PASSTHRU = 8'h1E;
	localparam logic [7:0] SBIR_RST_SCL_HIGH = 8'h7F;

	// Field positions
	localparam int unsigned SBIR_STRAP_B_DONE_BIT = 7;
	localparam int unsigned SBIR_STRAP_B_DEC_LSB = 4;
	localparam int unsigned SBIR_STRAP_A_DONE_BIT = 3;
	localparam int unsigned SBIR_STRAP_A_DEC_LSB = 0;
	localparam int unsigned SBIR_BIST_EN_BIT = 0;
	localparam int unsigned SBIR_BIST_SRC_LSB = 1;
	localparam int unsigned SBIR_WD_DIS_BIT = 0;
	localparam int unsigned SBIR_WD_TMO_LSB = 1;
	localparam int unsigned SBIR_PT_ALL_BIT = 7;
	localparam int unsigned SBIR_PT_HOLD_LSB = 4;
	localparam int unsigned SBIR_PT_FILT_LSB = 0;

	// Level select write keys
	localparam logic [7:0] SBIR_KEY_LEVEL_SET = 8'hB5;
	localparam logic [7:0] SBIR_KEY_LEVEL_CLR = 8'hB6;

	// Timing
	localparam longint unsigned SBIR_CLK_PERIOD_FS = 64'd10_000_000;
	localparam longint unsigned SBIR_WD_UNIT_MS = 64'd2;
	localparam longint unsigned SBIR_WD_UNIT_CYCLES =
		(SBIR_WD_UNIT_MS * 64'd1_000_000_000_000) / SBIR_CLK_PERIOD_FS;
	localparam longint unsigned SBIR_HOLD_STEP_NS = 64'd40;
	localparam longint unsigned SBIR_FILT_STEP_NS = 64'd5;
	localparam longint unsigned SBIR_SCL_UNIT_FS = 64'd38_095_200;
	localparam longint unsigned SBIR_SCL_EXTRA = 64'd5;
	localparam int unsigned SBIR_STRAP_SETTLE_CYCLES = 16;

	// Forward frame / self test clock source
	typedef enum logic [2:0] {
		SBIR_SRC_NONE,
		SBIR_SRC_EXT_PIXEL,
		SBIR_SRC_OSC_25,
		SBIR_SRC_OSC_33,
		SBIR_SRC_OSC_50,
		SBIR_SRC_OSC_100
	} sbir_clk_src_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sbir_bus_req_t;

	// Local I2C access seen by the pass-through filter
	typedef struct packed {
		logic valid;
		logic [6:0] target_id;
	} sbir_access_t;

endpackage

// ===== verilog/sbir_regs.sv
`timescale 1ns/1ps
`default_nettype none

module sbir_regs import sbir_pkg::*; #(
	parameter longint unsigned WD_UNIT_CYCLES = SBIR_WD_UNIT_CYCLES,
	parameter int unsigned STRAP_SETTLE = SBIR_STRAP_SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire sbir_bus_req_t bus_req,
	output logic [7:0] rdata_q,
	input wire logic [2:0] mode_strap_pin_a,
	input wire logic [2:0] mode_strap_pin_b,
	input wire logic bus_level_strap,
	input wire logic digital_reset,
	input wire logic tmds_clock_present,
	input wire logic osc_frame_enable,
	input wire logic second_link_select,
	input wire logic bidir_ctrl_channel_start,
	input wire logic bidir_ctrl_channel_done,
	input wire sbir_access_t access,
	input wire logic [6:0] serializer_id,
	input wire logic [6:0] remote_deser_id,
	input wire logic [6:0] remote_target_id,
	output sbir_clk_src_t frame_oscillator_source_q,
	output logic self_test_enable_q,
	output logic bus_level_choice_q,
	output logic watchdog_abort_q,
	output logic forward_q,
	output logic forward_link1_q,
	output logic [5:0] sda_hold_cycles_q,
	output logic [3:0] filter_reject_cycles_q,
	output logic [9:0] scl_high_cycles_q
);

	// Derived cycle counts, rounded up except the filter
	function automatic logic [9:0] scl_cycles(input logic [7:0] f);
		longint unsigned t;
		t = (longint'(f) + SBIR_SCL_EXTRA) * SBIR_SCL_UNIT_FS;
		scl_cycles = 10'((t + SBIR_CLK_PERIOD_FS - 64'd1) / SBIR_CLK_PERIOD_FS);
	endfunction

	function automatic logic [5:0] hold_cycles(input logic [2:0] f);
		longint unsigned t;
		t = longint'(f) * SBIR_HOLD_STEP_NS * 64'd1_000_000;
		hold_cycles = 6'((t + SBIR_CLK_PERIOD_FS - 64'd1) / SBIR_CLK_PERIOD_FS);
	endfunction

	function automatic logic [3:0] filt_cycles(input logic [3:0] f);
		longint unsigned t;
		t = longint'(f) * SBIR_FILT_STEP_NS * 64'd1_000_000;
		filt_cycles = 4'(t / SBIR_CLK_PERIOD_FS);
	endfunction

	// Write strobe aimed at one register
	function automatic logic reg_write(input sbir_bus_req_t req, input logic [7:0] a);
		reg_write = req.wr && (req.addr == a);
	endfunction

	typedef enum logic [1:0] {
		SBIR_STRAP_WAIT,
		SBIR_STRAP_LATCH,
		SBIR_STRAP_DONE
	} sbir_strap_state_t;

	typedef enum logic {
		SBIR_WD_IDLE,
		SBIR_WD_RUN
	} sbir_wd_state_t;

	// Register state
	sbir_strap_state_t strap_state_q;
	logic [15:0] settle_cnt_q;
	logic strap_done_q;
	logic [2:0] strap_a_q;
	logic [2:0] strap_b_q;
	logic [2:0] self_test_q;
	logic [7:0] watchdog_q;
	logic pass_all_link0_q;
	logic pass_all_link1_q;
	logic [2:0] hold_field_q;
	logic [3:0] filt_field_q;
	logic [7:0] scl_high_q;
	sbir_wd_state_t wd_state_q;
	logic [31:0] wd_tick_q;
	logic [6:0] wd_units_q;
	logic [6:0] wd_limit;
	logic pass_all_sel;
	logic [7:0] rd_mux;

	assign pass_all_sel = second_link_select ? pass_all_link1_q : pass_all_link0_q;
	// Timeout field zero acts as one
	assign wd_limit = (watchdog_q[7:SBIR_WD_TMO_LSB] == 7'h00) ? 7'h01 :
		watchdog_q[7:SBIR_WD_TMO_LSB];

	// Strap settle and capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_state_q <= SBIR_STRAP_WAIT;
			settle_cnt_q <= 16'h0000;
			strap_done_q <= 1'b0;
			strap_a_q <= 3'h0;
			strap_b_q <= 3'h0;
		end else begin
			case (strap_state_q)
				SBIR_STRAP_WAIT: begin
					settle_cnt_q <= settle_cnt_q + 16'h0001;
					if (settle_cnt_q >= 16'(STRAP_SETTLE)) begin
						strap_state_q <= SBIR_STRAP_LATCH;
					end
				end
				SBIR_STRAP_LATCH: begin
					strap_b_q <= mode_strap_pin_b;
					strap_a_q <= {1'b0, mode_strap_pin_a[1:0]};
					strap_done_q <= 1'b1;
					strap_state_q <= SBIR_STRAP_DONE;
				end
				SBIR_STRAP_DONE: begin
					strap_done_q <= 1'b1;
				end
				default: begin
					strap_state_q <= SBIR_STRAP_WAIT;
				end
			endcase
		end
	end

	// Level choice: strap at power-up, digital reset, write keys
	logic level_loaded_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level_loaded_q <= 1'b0;
			bus_level_choice_q <= SBIR_RST_LEVEL_SEL[0];
		end else begin
			level_loaded_q <= 1'b1;
			if (digital_reset) begin
				bus_level_choice_q <= 1'b1;
			end else if (!level_loaded_q) begin
				bus_level_choice_q <= ~bus_level_strap;
			end else if (reg_write(bus_req, SBIR_ADDR_LEVEL_SEL)) begin
				if (bus_req.wdata == SBIR_KEY_LEVEL_SET) begin
					bus_level_choice_q <= 1'b1;
				end else if (bus_req.wdata == SBIR_KEY_LEVEL_CLR) begin
					bus_level_choice_q <= 1'b0;
				end
			end
		end
	end

	// Self test register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			self_test_q <= SBIR_RST_SELF_TEST[2:0];
		end else if (reg_write(bus_req, SBIR_ADDR_SELF_TEST)) begin
			self_test_q <= bus_req.wdata[2:0];
		end
	end

	// Watchdog control register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_q <= SBIR_RST_WATCHDOG;
		end else if (reg_write(bus_req, SBIR_ADDR_WATCHDOG)) begin
			watchdog_q <= bus_req.wdata;
		end
	end

	// Pass-through and filter register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pass_all_link0_q <= SBIR_RST_PASSTHRU[SBIR_PT_ALL_BIT];
			pass_all_link1_q <= SBIR_RST_PASSTHRU[SBIR_PT_ALL_BIT];
			hold_field_q <= SBIR_RST_PASSTHRU[6:4];
			filt_field_q <= SBIR_RST_PASSTHRU[3:0];
		end else if (reg_write(bus_req, SBIR_ADDR_PASSTHRU)) begin
			if (second_link_select) begin
				pass_all_link1_q <= bus_req.wdata[SBIR_PT_ALL_BIT];
			end else begin
				pass_all_link0_q <= bus_req.wdata[SBIR_PT_ALL_BIT];
			end
			hold_field_q <= bus_req.wdata[SBIR_PT_HOLD_LSB +: 3];
			filt_field_q <= bus_req.wdata[SBIR_PT_FILT_LSB +: 4];
		end
	end

	// SCL high time register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_high_q <= SBIR_RST_SCL_HIGH;
		end else if (reg_write(bus_req, SBIR_ADDR_SCL_HIGH)) begin
			scl_high_q <= bus_req.wdata;
		end
	end

	// Register read mux
	always_comb begin
		rd_mux = 8'h00;
		case (bus_req.addr)
			SBIR_ADDR_MODE_STRAP: begin
				rd_mux[SBIR_STRAP_B_DONE_BIT] = strap_done_q;
				rd_mux[SBIR_STRAP_B_DEC_LSB +: 3] = strap_b_q;
				rd_mux[SBIR_STRAP_A_DONE_BIT] = strap_done_q;
				rd_mux[SBIR_STRAP_A_DEC_LSB +: 3] = strap_a_q;
			end
			SBIR_ADDR_SELF_TEST: rd_mux[2:0] = self_test_q;
			SBIR_ADDR_LEVEL_SEL: rd_mux[0] = bus_level_choice_q;
			SBIR_ADDR_WATCHDOG: rd_mux = watchdog_q;
			SBIR_ADDR_PASSTHRU: begin
				rd_mux[SBIR_PT_ALL_BIT] = pass_all_sel;
				rd_mux[SBIR_PT_HOLD_LSB +: 3] = hold_field_q;
				rd_mux[SBIR_PT_FILT_LSB +: 4] = filt_field_q;
			end
			SBIR_ADDR_SCL_HIGH: rd_mux = scl_high_q;
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data stands one cycle, idle zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (bus_req.rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// Clock source selection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_oscillator_source_q <= SBIR_SRC_NONE;
			self_test_enable_q <= 1'b0;
		end else begin
			self_test_enable_q <= self_test_q[SBIR_BIST_EN_BIT];
			if (self_test_q[SBIR_BIST_EN_BIT]) begin
				case (self_test_q[SBIR_BIST_SRC_LSB +: 2])
					2'h0: frame_oscillator_source_q <= SBIR_SRC_EXT_PIXEL;
					2'h1: frame_oscillator_source_q <= SBIR_SRC_OSC_33;
					default: frame_oscillator_source_q <= SBIR_SRC_OSC_100;
				endcase
			end else if (!tmds_clock_present && osc_frame_enable) begin
				case (self_test_q[SBIR_BIST_SRC_LSB +: 2])
					2'h2: frame_oscillator_source_q <= SBIR_SRC_OSC_100;
					2'h3: frame_oscillator_source_q <= SBIR_SRC_OSC_25;
					default: frame_oscillator_source_q <= SBIR_SRC_OSC_50;
				endcase
			end else begin
				frame_oscillator_source_q <= SBIR_SRC_NONE;
			end
		end
	end

	// Control channel watchdog
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_state_q <= SBIR_WD_IDLE;
			wd_tick_q <= 32'h0000_0000;
			wd_units_q <= 7'h00;
			watchdog_abort_q <= 1'b0;
		end else begin
			watchdog_abort_q <= 1'b0;
			case (wd_state_q)
				SBIR_WD_IDLE: begin
					wd_tick_q <= 32'h0000_0000;
					wd_units_q <= 7'h00;
					if (bidir_ctrl_channel_start && !watchdog_q[SBIR_WD_DIS_BIT]) begin
						wd_state_q <= SBIR_WD_RUN;
					end
				end
				SBIR_WD_RUN: begin
					if (watchdog_q[SBIR_WD_DIS_BIT] || bidir_ctrl_channel_done) begin
						wd_state_q <= SBIR_WD_IDLE;
					end else if (wd_tick_q == 32'(WD_UNIT_CYCLES - 64'd1)) begin
						wd_tick_q <= 32'h0000_0000;
						if (wd_units_q + 7'h01 >= wd_limit) begin
							watchdog_abort_q <= 1'b1;
							wd_state_q <= SBIR_WD_IDLE;
						end else begin
							wd_units_q <= wd_units_q + 7'h01;
						end
					end else begin
						wd_tick_q <= wd_tick_q + 32'h0000_0001;
					end
				end
				default: wd_state_q <= SBIR_WD_IDLE;
			endcase
		end
	end

	// Forwarding decision for local I2C accesses
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			forward_q <= 1'b0;
			forward_link1_q <= 1'b0;
		end else begin
			forward_link1_q <= second_link_select;
			forward_q <= access.valid && (access.target_id != serializer_id) &&
				(pass_all_sel || access.target_id == remote_deser_id ||
				access.target_id == remote_target_id);
		end
	end

	// Derived I2C timing counts
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_hold_cycles_q <= 6'h00;
			filter_reject_cycles_q <= 4'h0;
			scl_high_cycles_q <= 10'h000;
		end else begin
			sda_hold_cycles_q <= hold_cycles(hold_field_q);
			filter_reject_cycles_q <= filt_cycles(filt_field_q);
			scl_high_cycles_q <= scl_cycles(scl_high_q);
		end
	end

endmodule

`default_nettype wire

// ===== verification/sbir_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sbir_regs_checker import sbir_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire sbir_bus_req_t bus_req,
	input wire logic [7:0] rdata_q,
	input wire logic digital_reset,
	input wire sbir_access_t access,
	input wire logic [6:0] serializer_id,
	input wire logic [6:0] remote_deser_id,
	input wire logic self_test_enable_q,
	input wire logic bus_level_choice_q,
	input wire logic watchdog_abort_q,
	input wire logic forward_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic rd_a, rd_l, wr_b, wr_l, acc_s, acc_d;
	assign rd_a = bus_req.rd && bus_req.addr == SBIR_ADDR_MODE_STRAP;
	assign rd_l = bus_req.rd && bus_req.addr == SBIR_ADDR_LEVEL_SEL;
	assign wr_b = bus_req.wr && bus_req.addr == SBIR_ADDR_SELF_TEST;
	assign wr_l = bus_req.wr && bus_req.addr == SBIR_ADDR_LEVEL_SEL && !digital_reset;
	assign acc_s = access.valid && access.target_id == serializer_id;
	assign acc_d = access.valid && access.target_id == remote_deser_id && !acc_s;
	chk_rdata_idle: assert property (!bus_req.rd |=> rdata_q == 8'h00)
		else $error("read data not idle");
	chk_strap_a_top: assert property (rd_a |=> rdata_q[2] == 1'b0)
		else $error("strap A decode too wide");
	chk_bist_enable: assert property (wr_b ##1 !wr_b |=> self_test_enable_q ==
		$past(bus_req.wdata[0], 2)) else $error("self test enable wrong");
	chk_key_set: assert property (wr_l && $past(reset_n) && bus_req.wdata == 8'hB5
		|=> bus_level_choice_q) else $error("set key ignored");
	chk_key_clear: assert property (wr_l && $past(reset_n) && bus_req.wdata == 8'hB6
		|=> !bus_level_choice_q) else $error("clear key ignored");
	chk_other_value: assert property (wr_l && $past(reset_n) && bus_req.wdata != 8'hB5
		&& bus_req.wdata != 8'hB6 |=> $stable(bus_level_choice_q)) else $error("level changed");
	chk_dig_reset: assert property (digital_reset |=> bus_level_choice_q)
		else $error("digital reset missed");
	chk_level_read: assert property (rd_l |=> rdata_q == {7'h00, $past(bus_level_choice_q)})
		else $error("level read wrong");
	chk_abort_pulse: assert property (watchdog_abort_q |=> !watchdog_abort_q)
		else $error("abort too long");
	chk_no_self_fwd: assert property (acc_s |=> !forward_q)
		else $error("own access forwarded");
	chk_deser_fwd: assert property (acc_d |=> forward_q)
		else $error("remote access dropped");
	cover property (watchdog_abort_q);
	cover property (acc_d);
	cover property (digital_reset);
endmodule
bind sbir_regs sbir_regs_checker u_chk (.clk, .reset_n, .bus_req, .rdata_q, .digital_reset,
	.access, .serializer_id, .remote_deser_id, .self_test_enable_q, .bus_level_choice_q,
	.watchdog_abort_q, .forward_q);
`default_nettype wire

// ===== verification/sbir_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbir_far_model import sbir_pkg::*; (
	input wire logic clk,
	output sbir_access_t access,
	output logic bidir_ctrl_channel_start,
	output logic bidir_ctrl_channel_done,
	output logic [6:0] serializer_id,
	output logic [6:0] remote_deser_id,
	output logic [6:0] remote_target_id
);
	assign serializer_id = 7'h10;
	assign remote_deser_id = 7'h20;
	assign remote_target_id = 7'h30;
	initial begin
		access = '0;
		bidir_ctrl_channel_start = 1'b0;
		bidir_ctrl_channel_done = 1'b0;
	end
	// One access, then id line shows inverse
	task send(input logic [6:0] id);
		@(posedge clk);
		access <= {1'b1, id};
		@(posedge clk);
		access <= {1'b0, ~id};
	endtask
	task pulse_start;
		@(posedge clk);
		bidir_ctrl_channel_start <= 1'b1;
		@(posedge clk);
		bidir_ctrl_channel_start <= 1'b0;
	endtask
	task pulse_done;
		@(posedge clk);
		bidir_ctrl_channel_done <= 1'b1;
		@(posedge clk);
		bidir_ctrl_channel_done <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verification/sbir_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module sbir_regs_test import sbir_pkg::*;;
	logic clk, reset_n, bus_level_strap, digital_reset, tmds_clock_present, osc_frame_enable;
	logic second_link_select, bidir_ctrl_channel_start, bidir_ctrl_channel_done;
	logic self_test_enable_q, bus_level_choice_q, watchdog_abort_q, forward_q, forward_link1_q;
	logic [2:0] mode_strap_pin_a, mode_strap_pin_b;
	logic [6:0] serializer_id, remote_deser_id, remote_target_id;
	logic [7:0] rdata_q;
	logic [5:0] sda_hold_cycles_q;
	logic [3:0] filter_reject_cycles_q;
	logic [9:0] scl_high_cycles_q;
	sbir_bus_req_t bus_req;
	sbir_access_t access;
	sbir_clk_src_t frame_oscillator_source_q;
	int mismatches, samples_checked, n;
	sbir_clk_src_t src_tbl [8] = '{SBIR_SRC_OSC_50, SBIR_SRC_OSC_50, SBIR_SRC_OSC_100,
		SBIR_SRC_OSC_25, SBIR_SRC_EXT_PIXEL, SBIR_SRC_OSC_33, SBIR_SRC_OSC_100, SBIR_SRC_OSC_100};
	logic [7:0] rst_tbl [6] = '{8'hDA, 8'h00, 8'h00, 8'hFE, 8'h1E, 8'h7F};
	logic [6:0] ids [4] = '{7'h20, 7'h30, 7'h40, 7'h10};
	logic [7:0] fwd_exp = 8'h73;
	sbir_regs #(.WD_UNIT_CYCLES(10), .STRAP_SETTLE(2)) DUT (.clk, .reset_n, .bus_req, .rdata_q,
		.mode_strap_pin_a, .mode_strap_pin_b, .bus_level_strap, .digital_reset,
		.tmds_clock_present, .osc_frame_enable, .second_link_select, .bidir_ctrl_channel_start,
		.bidir_ctrl_channel_done, .access, .serializer_id, .remote_deser_id, .remote_target_id,
		.frame_oscillator_source_q, .self_test_enable_q, .bus_level_choice_q,
		.watchdog_abort_q, .forward_q, .forward_link1_q, .sda_hold_cycles_q,
		.filter_reject_cycles_q, .scl_high_cycles_q);
	sbir_far_model far (.clk, .access, .bidir_ctrl_channel_start, .bidir_ctrl_channel_done,
		.serializer_id, .remote_deser_id, .remote_target_id);
	task end_sim;
		if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= {a, d, 2'b10};
		@(posedge clk);
		bus_req <= {a, d, 2'b00};
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		bus_req <= {a, 8'h00, 2'b01};
		@(posedge clk);
		bus_req <= {a, 8'h00, 2'b00};
		#1 chk(rdata_q, e);
	endtask
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task rd_resets;
		for (int i = 0; i < 6; i++) rd(8'h13 + 8'(i), rst_tbl[i]);
	endtask
	task wait_abort;
		for (n = 0; n < 40 && !watchdog_abort_q; n++) begin
			@(posedge clk);
			#1;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300000;
		mismatches++;
		end_sim;
	end
	initial begin
		reset_n = 1'b0;
		bus_req = '0;
		mode_strap_pin_a = 3'h6;
		mode_strap_pin_b = 3'h5;
		bus_level_strap = 1'b1;
		digital_reset = 1'b0;
		tmds_clock_present = 1'b0;
		osc_frame_enable = 1'b1;
		second_link_select = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		rd_resets;
		rd(8'h20, 8'h00);
		chk(sda_hold_cycles_q, 16'h0004);
		chk(filter_reject_cycles_q, 16'h0007);
		chk(scl_high_cycles_q, 16'h01F7);
		wr(8'h13, 8'h00);
		rd(8'h13, 8'hDA);
		@(posedge clk);
		digital_reset <= 1'b1;
		@(posedge clk);
		digital_reset <= 1'b0;
		rd(8'h15, 8'h01);
		wr(8'h15, SBIR_KEY_LEVEL_CLR);
		rd(8'h15, 8'h00);
		wr(8'h15, 8'h55);
		rd(8'h15, 8'h00);
		wr(8'h15, SBIR_KEY_LEVEL_SET);
		rd(8'h15, 8'h01);
		wr(8'h15, 8'hB7);
		rd(8'h15, 8'h01);
		for (int i = 0; i < 8; i++) begin
			wr(8'h14, {5'h00, 2'(i), i[2]});
			settle;
			chk(frame_oscillator_source_q, src_tbl[i]);
			chk(self_test_enable_q, i[2]);
		end
		@(posedge clk);
		tmds_clock_present <= 1'b1;
		settle;
		chk(frame_oscillator_source_q, SBIR_SRC_OSC_100);
		wr(8'h14, 8'h04);
		settle;
		chk(frame_oscillator_source_q, SBIR_SRC_NONE);
		@(posedge clk);
		tmds_clock_present <= 1'b0;
		osc_frame_enable <= 1'b0;
		settle;
		chk(frame_oscillator_source_q, SBIR_SRC_NONE);
		@(posedge clk);
		osc_frame_enable <= 1'b1;
		settle;
		chk(frame_oscillator_source_q, SBIR_SRC_OSC_100);
		wr(8'h14, 8'hFF);
		rd(8'h14, 8'h07);
		wr(8'h14, 8'h00);
		wr(8'h16, 8'h04);
		far.pulse_start;
		wait_abort;
		chk(n >= 19 && n <= 23, 16'h0001);
		far.pulse_start;
		repeat (5) @(posedge clk);
		far.pulse_done;
		wait_abort;
		chk(16'(n), 16'h0028);
		wr(8'h16, 8'h05);
		far.pulse_start;
		wait_abort;
		chk(16'(n), 16'h0028);
		for (int i = 0; i < 8; i++) begin
			if (i == 4) wr(8'h17, 8'h9E);
			far.send(ids[i % 4]);
			#1 chk(forward_q, fwd_exp[i]);
		end
		@(posedge clk);
		second_link_select <= 1'b1;
		rd(8'h17, 8'h1E);
		chk(forward_link1_q, 16'h0001);
		far.send(7'h40);
		#1 chk(forward_q, 16'h0000);
		wr(8'h17, 8'h9E);
		far.send(7'h40);
		#1 chk(forward_q, 16'h0001);
		@(posedge clk);
		second_link_select <= 1'b0;
		rd(8'h17, 8'h9E);
		chk(forward_link1_q, 16'h0000);
		wr(8'h17, 8'h38);
		wr(8'h18, 8'h00);
		settle;
		chk(sda_hold_cycles_q, 16'h000C);
		chk(filter_reject_cycles_q, 16'h0004);
		chk(scl_high_cycles_q, 16'h0014);
		wr(8'h18, 8'hFF);
		settle;
		chk(scl_high_cycles_q, 16'h03DF);
		rd(8'h18, 8'hFF);
		@(posedge clk);
		reset_n <= 1'b0;
		bus_level_strap <= 1'b0;
		mode_strap_pin_a <= 3'h1;
		mode_strap_pin_b <= 3'h2;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		rst_tbl[0] = 8'hA9;
		rst_tbl[2] = 8'h01;
		rd_resets;
		end_sim;
	end
endmodule
`default_nettype wire
